// [shared/ldpt_pkg.sv]
package ldpt_pkg;
  // ===========================================================
  // register map (byte addresses)
  localparam logic [7:0] LDPT_OFF_THREE_OF_FIVE = 8'h50;
  localparam logic [7:0] LDPT_OFF_SIX_OF_SEVEN = 8'h54;
  localparam logic [7:0] LDPT_OFF_FIVE_OF_SEVEN = 8'h58;
  localparam logic [7:0] LDPT_OFF_FOUR_OF_SEVEN = 8'h5C;
  localparam logic [7:0] LDPT_OFF_STATUS = 8'h60;
  // ===========================================================
  // field widths and periods
  localparam int LDPT_W5 = 20;
  localparam int LDPT_W7 = 28;
  localparam logic [2:0] LDPT_PERIOD5 = 3'h5;
  localparam logic [2:0] LDPT_PERIOD7 = 3'h7;
  // ===========================================================
  // reset values (tables power up undefined; cleared here)
  localparam logic [19:0] LDPT_RST5 = 20'h00000;
  localparam logic [27:0] LDPT_RST7 = 28'h0000000;
  localparam logic [3:0] LDPT_SHADE_MAX = 4'hF;
endpackage

// [tb/ldpt_checker.sv]
`timescale 1ns/10ps
// =====
// register port and pixel checks
module ldpt_checker (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic pix_valid_i, // shade valid
  input wire logic [3:0] shade_i, // shade
  input wire logic pix_o, // pixel
  input wire logic pix_valid_o // pixel valid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a taken request; only the status place may read back non-zero
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_blind;
    s_req ##0 !wb_we_i && wb_adr_i != 8'h60;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_write_only: assert property (s_rd_blind |=> wb_dat_o == 32'h0)
    else $error("readable data");
  a_pix_follow: assert property (pix_valid_i |=> pix_valid_o)
    else $error("valid lost");
  a_pix_idle: assert property (!pix_valid_i |=> !pix_valid_o)
    else $error("stray valid");
  a_shade_off: assert property (pix_valid_i && shade_i == 4'h0 |=> !pix_o)
    else $error("dark shade lit");
  a_shade_on: assert property (pix_valid_i && shade_i > 4'h8 |=> pix_o)
    else $error("full shade dark");
endmodule // ldpt_checker

// [tb/ldpt_top_tb.sv]
`timescale 1ns/10ps
// =====
// bench top
module ldpt_top_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, pix_o;
  logic line_start_i = 0, frame_start_i = 0, pix_valid_i = 0, pix_valid_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, shade_i = 0, sel_v = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  // suggested line patterns, line zero in the top nibble
  logic [27:0] tab [4] = '{28'h7A5AD, 28'hFBFDFE7, 28'h7B5ADEF, 28'hB9DC663};
  int km [9] = '{0, 1, 2, 0, 3, 3, 0, 2, 1};
  int num_errors = 0, checks_done = 0;
  ldpt_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_start_i(line_start_i),
    .frame_start_i(frame_start_i), .pix_valid_i(pix_valid_i), .shade_i(shade_i),
    .pix_o(pix_o), .pix_valid_o(pix_valid_o));
  always #50 clk_i = ~clk_i;
  task conclude;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ack is read before this edge's updates land, so it is the sampled value
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++i < 8);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      conclude;
    end
    @(posedge clk_i);
  endtask
  // inverted table for shades below five, taken from shade nine minus s
  task pix(input int s, input int f, input int l);
    logic [3:0] n;
    n = km[s] == 0 ? tab[0][19 - 4 * (l % 5) -: 4] : tab[km[s]][27 - 4 * (l % 7) -: 4];
    pix_valid_i <= 1;
    shade_i <= s[3:0];
    @(posedge clk_i);
    pix_valid_i <= 0;
    @(posedge clk_i);
    chk(pix_o, s == 0 ? 0 : s > 8 ? 1 : n[f] ^ (s < 5));
  endtask
  task step(input logic ls, input logic fs);
    line_start_i <= ls;
    frame_start_i <= fs;
    @(posedge clk_i);
    line_start_i <= 0;
    frame_start_i <= 0;
    @(posedge clk_i);
  endtask
  // =====
  // main sequence; ones above each field must not disturb it
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 8'h50, {12'hFFF, tab[0][19:0]});
    wb(1, 8'h54, {4'hF, tab[1]});
    wb(1, 8'h58, {4'hF, tab[2]});
    wb(1, 8'h5C, {4'hF, tab[3]});
    wb(1, 8'h70, 32'hFFFFFFFF);
    wb(0, 8'h70, 0);
    chk(rd, 0);
    for (int f = 0; f < 4; f++) begin
      for (int l = 0; l < 10; l++) begin
        for (int s = 0; s < 16; s++) pix(s, f, l);
        step(1, 0);
      end
      wb(0, 8'h60, 0);
      chk(rd, {f[1:0], 6'h18});
      step(0, 1);
    end
    // lane 0 only: lines three and four of three-of-five clear, line two stays
    sel_v = 4'h1;
    wb(1, 8'h50, 32'h00000000);
    step(0, 1);
    repeat (3) step(1, 0);
    pix_valid_i <= 1;
    shade_i <= 4'h6;
    @(posedge clk_i);
    pix_valid_i <= 0;
    @(posedge clk_i);
    chk(pix_o, 32'h0);
    conclude;
  end
endmodule // ldpt_top_tb
bind ldpt_top ldpt_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pix_valid_i(pix_valid_i), .shade_i(shade_i), .pix_o(pix_o),
  .pix_valid_o(pix_valid_o));

// [verilog/ldpt_top.sv]
`timescale 1ns/10ps
module ldpt_top (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic line_start_i, // pulse: new display line
  input wire logic frame_start_i, // pulse: new frame, line index to zero
  input wire logic pix_valid_i, // shade input valid
  input wire logic [3:0] shade_i, // 4-bit shade 0..15
  output logic pix_o, // dithered on/off pixel
  output logic pix_valid_o // pix_o valid
);
  import ldpt_pkg::*;

  // ===========================================================
  // state
  typedef struct packed {
    logic [19:0] t35;
    logic [27:0] t67;
    logic [27:0] t57;
    logic [27:0] t47;
    logic [2:0] line5;
    logic [2:0] line7;
    logic [1:0] frame;
    logic [31:0] dat;
    logic ack;
    logic pix;
    logic pvld;
  } ldpt_state_s;

  ldpt_state_s s_q;
  ldpt_state_s s_d;

  // nibble select: line 0 is the top nibble
  function automatic logic [3:0] ldpt_nib7(input logic [27:0] t, input logic [2:0] ln);
    ldpt_nib7 = t[(3'd6 - ln) * 4 +: 4];
  endfunction

  function automatic logic [3:0] ldpt_nib5(input logic [19:0] t, input logic [2:0] ln);
    ldpt_nib5 = t[(3'd4 - ln) * 4 +: 4];
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] ldpt_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    ldpt_merge = r;
  endfunction

  logic req;
  logic [31:0] m;
  logic [3:0] e35, e67, e57, e47;
  logic b;

  // ===========================================================
  // next state
  always_comb begin
    s_d = s_q;
    req = wb_cyc_i && wb_stb_i && !s_q.ack;
    m = 32'h0;
    e35 = 4'h0;
    e67 = 4'h0;
    e57 = 4'h0;
    e47 = 4'h0;
    b = 1'b0;
    // single-cycle ack; reads of tables return zero since they are write-only
    s_d.ack = req;
    s_d.dat = 32'h0;
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        LDPT_OFF_THREE_OF_FIVE: begin
          m = ldpt_merge({12'h0, s_q.t35}, wb_dat_i, wb_sel_i);
          s_d.t35 = m[19:0];
        end
        LDPT_OFF_SIX_OF_SEVEN: begin
          m = ldpt_merge({4'h0, s_q.t67}, wb_dat_i, wb_sel_i);
          s_d.t67 = m[27:0];
        end
        LDPT_OFF_FIVE_OF_SEVEN: begin
          m = ldpt_merge({4'h0, s_q.t57}, wb_dat_i, wb_sel_i);
          s_d.t57 = m[27:0];
        end
        LDPT_OFF_FOUR_OF_SEVEN: begin
          m = ldpt_merge({4'h0, s_q.t47}, wb_dat_i, wb_sel_i);
          s_d.t47 = m[27:0];
        end
        default: begin
          m = 32'h0; // unmapped writes are acked and dropped
        end
      endcase
    end else if (req) begin
      // status readback shows the dither position; everything else reads zero
      if (wb_adr_i == LDPT_OFF_STATUS) begin
        s_d.dat = {24'h0, s_q.frame, s_q.line7, s_q.line5};
      end
    end
    // line and frame position counters
    if (frame_start_i) begin
      s_d.line5 = 3'h0;
      s_d.line7 = 3'h0;
      s_d.frame = s_q.frame + 2'h1;
    end else if (line_start_i) begin
      s_d.line5 = (s_q.line5 == LDPT_PERIOD5 - 3'h1) ? 3'h0 : s_q.line5 + 3'h1;
      s_d.line7 = (s_q.line7 == LDPT_PERIOD7 - 3'h1) ? 3'h0 : s_q.line7 + 3'h1;
    end
    // pick the line entries for this line
    e35 = ldpt_nib5(s_q.t35, s_q.line5);
    e67 = ldpt_nib7(s_q.t67, s_q.line7);
    e57 = ldpt_nib7(s_q.t57, s_q.line7);
    e47 = ldpt_nib7(s_q.t47, s_q.line7);
    // shade to duty map; shades 1 to 8 are dithered from the four tables,
    // shade 0 is always off and shades 9 to 15 are always on
    unique case (shade_i)
      4'h0: b = 1'b0;
      4'h1: b = ~e67[s_q.frame];
      4'h2: b = ~e57[s_q.frame];
      4'h3: b = ~e35[s_q.frame];
      4'h4: b = ~e47[s_q.frame];
      4'h5: b = e47[s_q.frame];
      4'h6: b = e35[s_q.frame];
      4'h7: b = e57[s_q.frame];
      4'h8: b = e67[s_q.frame];
      default: b = (shade_i >= 4'h9);
    endcase
    s_d.pix = pix_valid_i & b;
    s_d.pvld = pix_valid_i;
  end

  // ===========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{t35: LDPT_RST5, t67: LDPT_RST7, t57: LDPT_RST7, t47: LDPT_RST7,
               line5: 3'h0, line7: 3'h0, frame: 2'h0, dat: 32'h0,
               ack: 1'b0, pix: 1'b0, pvld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign pix_o = s_q.pix;
  assign pix_valid_o = s_q.pvld;
endmodule // ldpt_top
